// *** hw/tpg_pkg.sv ***
`default_nettype none
package tpg_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SP_DAT = 8'h07;
    localparam logic [7:0] IDX_SC_DAT = 8'h08;
    localparam logic [7:0] IDX_ST_DAT = 8'h09;
    localparam logic [7:0] IDX_SP_DIR = 8'h87;
    localparam logic [7:0] IDX_SC_DIR = 8'h88;
    localparam logic [7:0] IDX_ST_CSR = 8'h89;
    localparam logic [7:0] IDX_ANALOG = 8'h9f;
    // control/status fields
    localparam int BIT_IN_FULL  = 7;
    localparam int BIT_OUT_FULL = 6;
    localparam int BIT_IN_OVF   = 5;
    localparam int BIT_MODE     = 4;
    // reset values
    localparam logic [7:0] RST_DIR     = 8'hff;
    localparam logic [2:0] RST_ST_DIR  = 3'h7;
    localparam logic [2:0] RST_ANALOG  = 3'h0;
    // analog select codes with both top bits set leave strobe pins digital
    localparam logic [1:0] AN_DIGITAL  = 2'h3;
    // shared pin functions
    localparam int FN_TMR_CLK  = 0;
    localparam int FN_CCP_TWO  = 1;
    localparam int FN_CCP_ONE  = 2;
    localparam int FN_SER_CLK  = 3;
    localparam int FN_SER_DIN  = 4;
    localparam int FN_SER_DOUT = 5;
    localparam int FN_UART_TX  = 6;
    localparam int FN_UART_RX  = 7;
    // strobe pins in slave mode
    localparam int ST_RD = 0;
    localparam int ST_WR = 1;
    localparam int ST_CS = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] dout;
        logic [7:0] oe;
    } tpg_periph_t;

    typedef struct packed {
        logic [7:0]  sp_dat, sp_dir, sc_dat, sc_dir, sc_in;
        logic [2:0]  st_dat, st_dir, an_sel;
        logic        in_full, out_full, in_ovf, slv_mode;
        logic [7:0]  sp_s1, sp_s2, sc_s1, sc_s2;
        logic [2:0]  st_s1, st_s2;
        logic        wr_act, rd_act, wr_pend, hready, ttl;
        logic [7:0]  wr_idx;
        logic [31:0] hrdata;
        logic [7:0]  sp_out, sp_oe, sc_out, sc_oe;
        logic [2:0]  st_out, st_oe;
    } tpg_state_t;

    localparam tpg_state_t RST_STATE = '{sp_dir: RST_DIR, sc_dir: RST_DIR,
        st_dir: RST_ST_DIR, an_sel: RST_ANALOG, hready: 1'b1, default: '0};
endpackage
`default_nettype wire

// *** hw/tpg_top.sv ***
// What this block does
// - shared 8-bit port, each pin's direction set by its own bit
// - enabled peripheral overrides shared pin direction, to output or input
// - per-pin select picks port latch or peripheral output
// - peripheral output enable acts only while its select is active
// - shared bits 3,4,5 serve serial port; 6,7 serve the uart
// - shared bits 0,1,2 serve timer clock and capture units
// - second 8-bit port, Schmitt inputs, per-pin direction
// - slave mode turns second port into 8-bit microprocessor data port
// - Schmitt buffers in I/O mode, TTL while slave mode selected
// - variant without slave port omits second and third ports
// - third port of three pins, each with own direction bit
// - slave mode strobes: bit0 read, bit1 write, bit2 select, low active
// - strobe pin selected analog reads zero
// - direction bits still act in analog use; software keeps inputs
// - after reset strobe pins are analog and read zero
// - input full flag: set when word received, cleared by core read
// - output full flag: set on core write, clear once read
// - overflow set on write to unread buffer, sticky until cleared
// - mode bit selects slave mode, resets zero; bit 3 reads zero
// - low three status bits are strobe pin directions, reset to one
// - direction one floats the pin, zero drives the latch
// - data read returns pins, data write updates latch
// - outside slave mode full flags held clear, overflow stays
// - slave mode ignores second port direction register
//
// Added by the designer: the AHB-Lite register port.
`default_nettype none
module tpg_top #(
    parameter bit HAS_SLAVE_PORT = 1'b1
) (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // shared port pins
    input  wire logic [7:0]           sp_pin_in,
    output logic      [7:0]           sp_pin_out,
    output logic      [7:0]           sp_pin_oe,
    // on-chip peripherals on the shared port
    input  wire tpg_pkg::tpg_periph_t periph_ctl,
    output logic      [7:0]           periph_pin_in,
    // slave-capable port pins
    input  wire logic [7:0]           sc_pin_in,
    output logic      [7:0]           sc_pin_out,
    output logic      [7:0]           sc_pin_oe,
    // strobe port pins
    input  wire logic [2:0]           st_pin_in,
    output logic      [2:0]           st_pin_out,
    output logic      [2:0]           st_pin_oe,
    // input buffer type of second and third ports, 1 = ttl
    output logic                      input_buffer_ttl
);
    tpg_pkg::tpg_state_t s;
    tpg_pkg::tpg_state_t nxt_s;

    // ------------------------------------------------
    // derived terms
    // ------------------------------------------------
    logic       slv_on;
    logic       st_digital;
    logic [2:0] st_read;
    logic       wr_now;
    logic       rd_now;
    logic       wr_done;
    logic       rd_start;
    logic       take;
    logic       take_rd;
    logic [7:0] idx;
    logic       hi_zero;
    logic       wr_ok;

    assign slv_on     = HAS_SLAVE_PORT && s.slv_mode;
    assign st_digital = (s.an_sel[2:1] == tpg_pkg::AN_DIGITAL);
    // analog pins read zero; reset leaves them analog
    assign st_read    = st_digital ? s.st_s2 : 3'h0;
    // strobes are synchronised and low active
    assign wr_now     = slv_on && !s.st_s2[tpg_pkg::ST_CS]
                               && !s.st_s2[tpg_pkg::ST_WR];
    assign rd_now     = slv_on && !s.st_s2[tpg_pkg::ST_CS]
                               && !s.st_s2[tpg_pkg::ST_RD];
    assign wr_done    = slv_on && s.wr_act && !wr_now;
    assign rd_start   = rd_now && !s.rd_act;
    assign take       = hsel && hready && (htrans == tpg_pkg::HTRANS_NONSEQ);
    assign take_rd    = take && !hwrite;
    assign idx        = haddr[9:2];
    assign hi_zero    = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
    assign wr_ok      = s.wr_pend;

    // ------------------------------------------------
    // next state
    // ------------------------------------------------
    always_comb begin
        logic       slv_idx;
        logic       hit;
        logic       core_rd_in;
        logic       core_wr_out;
        logic [7:0] rdv;
        slv_idx     = 1'b0;
        hit         = 1'b0;
        core_rd_in  = 1'b0;
        core_wr_out = 1'b0;
        rdv         = 8'h00;
        nxt_s       = s;

        // two-stage synchronisers on every pin
        nxt_s.sp_s1 = sp_pin_in;
        nxt_s.sp_s2 = s.sp_s1;
        nxt_s.sc_s1 = sc_pin_in;
        nxt_s.sc_s2 = s.sc_s1;
        nxt_s.st_s1 = st_pin_in;
        nxt_s.st_s2 = s.st_s1;

        // external bus cycles
        nxt_s.wr_act = wr_now;
        nxt_s.rd_act = rd_now;
        // latch follows the pins while the write is open
        if (wr_now) begin
            nxt_s.sc_in = s.sc_s2;
        end

        // address phase: decode and read
        slv_idx = (idx == tpg_pkg::IDX_SC_DAT) || (idx == tpg_pkg::IDX_ST_DAT) ||
                  (idx == tpg_pkg::IDX_SC_DIR) || (idx == tpg_pkg::IDX_ST_CSR);
        hit = hi_zero && (!slv_idx || HAS_SLAVE_PORT);
        case (idx)
            tpg_pkg::IDX_SP_DAT: begin
                rdv = s.sp_s2;
            end
            tpg_pkg::IDX_SP_DIR: begin
                rdv = s.sp_dir;
            end
            tpg_pkg::IDX_SC_DAT: begin
                // slave mode reads the input latch
                rdv = slv_on ? s.sc_in : s.sc_s2;
            end
            tpg_pkg::IDX_SC_DIR: begin
                rdv = s.sc_dir;
            end
            tpg_pkg::IDX_ST_DAT: begin
                rdv = {5'h00, st_read};
            end
            tpg_pkg::IDX_ST_CSR: begin
                // bit 3 unimplemented, reads zero
                rdv = {s.in_full, s.out_full, s.in_ovf, s.slv_mode,
                       1'b0, s.st_dir};
            end
            tpg_pkg::IDX_ANALOG: begin
                rdv = {5'h00, s.an_sel};
            end
            default: begin
                rdv = 8'h00;
            end
        endcase
        if (take_rd) begin
            nxt_s.hrdata = hit ? {24'h00_0000, rdv} : 32'h0000_0000;
            core_rd_in   = hit && slv_on && (idx == tpg_pkg::IDX_SC_DAT);
        end
        nxt_s.wr_pend = take && hwrite && hit;
        if (take && hwrite) begin
            nxt_s.wr_idx = idx;
        end

        // data phase: write
        if (wr_ok) begin
            case (s.wr_idx)
                tpg_pkg::IDX_SP_DAT: begin
                    nxt_s.sp_dat = hwdata[7:0];
                end
                tpg_pkg::IDX_SP_DIR: begin
                    nxt_s.sp_dir = hwdata[7:0];
                end
                tpg_pkg::IDX_SC_DAT: begin
                    nxt_s.sc_dat = hwdata[7:0];
                    core_wr_out  = slv_on;
                end
                tpg_pkg::IDX_SC_DIR: begin
                    nxt_s.sc_dir = hwdata[7:0];
                end
                tpg_pkg::IDX_ST_DAT: begin
                    nxt_s.st_dat = hwdata[2:0];
                end
                tpg_pkg::IDX_ST_CSR: begin
                    nxt_s.in_ovf   = hwdata[tpg_pkg::BIT_IN_OVF];
                    nxt_s.slv_mode = hwdata[tpg_pkg::BIT_MODE];
                    nxt_s.st_dir   = hwdata[2:0];
                end
                tpg_pkg::IDX_ANALOG: begin
                    nxt_s.an_sel = hwdata[2:0];
                end
                default: begin
                end
            endcase
        end

        // status flags; hardware set wins over software clear
        if (core_rd_in) begin
            nxt_s.in_full = 1'b0;
        end
        if (wr_done) begin
            nxt_s.in_full = 1'b1;
            if (s.in_full) begin
                nxt_s.in_ovf = 1'b1;
            end
        end
        if (rd_start) begin
            nxt_s.out_full = 1'b0;
        end
        if (core_wr_out) begin
            nxt_s.out_full = 1'b1;
        end
        // overflow is left alone here
        if (!nxt_s.slv_mode || !HAS_SLAVE_PORT) begin
            nxt_s.in_full  = 1'b0;
            nxt_s.out_full = 1'b0;
        end

        // shared port: peripheral takes pin and direction when selected
        for (int i = 0; i < 8; i++) begin
            if (periph_ctl.sel[i]) begin
                nxt_s.sp_out[i] = periph_ctl.dout[i];
                nxt_s.sp_oe[i]  = periph_ctl.oe[i];
            end else begin
                nxt_s.sp_out[i] = s.sp_dat[i];
                nxt_s.sp_oe[i]  = !s.sp_dir[i];
            end
        end

        // slave-capable port: external bus owns direction in slave mode
        if (slv_on) begin
            nxt_s.sc_out = s.sc_dat;
            nxt_s.sc_oe  = rd_now ? 8'hff : 8'h00;
        end else begin
            nxt_s.sc_out = s.sc_dat;
            nxt_s.sc_oe  = ~s.sc_dir;
        end

        // strobe port: direction acts even while analog
        nxt_s.st_out = s.st_dat;
        nxt_s.st_oe  = ~s.st_dir;
        if (!HAS_SLAVE_PORT) begin
            nxt_s.sc_oe = 8'h00;
            nxt_s.st_oe = 3'h0;
        end
        nxt_s.ttl    = slv_on;
        nxt_s.hready = 1'b1;
    end

    // ------------------------------------------------
    // state register
    // ------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= tpg_pkg::RST_STATE;
        end else begin
            s <= nxt_s;
        end
    end

    // ------------------------------------------------
    // outputs
    // ------------------------------------------------
    assign hrdata           = s.hrdata;
    assign hreadyout        = s.hready;
    assign hresp            = 1'b0;
    assign sp_pin_out       = s.sp_out;
    assign sp_pin_oe        = s.sp_oe;
    // serial, uart, timer and capture units see the pins here
    assign periph_pin_in    = s.sp_s2;
    assign sc_pin_out       = s.sc_out;
    assign sc_pin_oe        = s.sc_oe;
    assign st_pin_out       = s.st_out;
    assign st_pin_oe        = s.st_oe;
    assign input_buffer_ttl = s.ttl;

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic csr_write;
    assign csr_write = wr_ok && (s.wr_idx == tpg_pkg::IDX_ST_CSR);

    sequence ext_write_end;
        wr_done;
    endsequence
    sequence core_data_write;
        wr_ok && slv_on && (s.wr_idx == tpg_pkg::IDX_SC_DAT);
    endsequence

    chk_in_full_set: assert property (
        ext_write_end ##1 s.slv_mode |-> s.in_full)
        else $error("input full not set after external write");
    chk_ovf_set: assert property (
        (ext_write_end and s.in_full) |=> s.in_ovf)
        else $error("overflow not set on second write");
    chk_ovf_sticky: assert property (
        s.in_ovf && !csr_write |=> s.in_ovf)
        else $error("overflow cleared without software");
    chk_flags_held_clear: assert property (
        !s.slv_mode |-> !s.in_full && !s.out_full)
        else $error("full flag set outside slave mode");
    chk_out_full_set: assert property (
        core_data_write |=> s.out_full)
        else $error("output full not set by core write");
    chk_out_full_clear: assert property (
        rd_start && !wr_ok ##1 s.slv_mode |-> !s.out_full)
        else $error("output full not cleared by external read");
    chk_analog_reads_zero: assert property (
        take_rd && hi_zero && idx == tpg_pkg::IDX_ST_DAT && !st_digital
        |=> s.hrdata[2:0] == 3'h0)
        else $error("analog strobe pin read nonzero");
    chk_override_oe: assert property (
        ##1 1'b1 |-> s.sp_oe == ($past(periph_ctl.sel & periph_ctl.oe)
                     | $past(~periph_ctl.sel & ~s.sp_dir)))
        else $error("shared pin enable wrong");
    chk_dir_drive: assert property (
        HAS_SLAVE_PORT && !slv_on |=> s.sc_oe == ~$past(s.sc_dir))
        else $error("slave-capable port direction not followed");
    chk_slave_ignores_dir: assert property (
        slv_on && !rd_now |=> s.sc_oe == 8'h00)
        else $error("second port driven outside external read");
    chk_bus_ready: assert property (
        s.hready && !hresp)
        else $error("bus answer not ready okay");

    // each check compares one register stage against what fed it
    sequence ext_write_open;
        wr_now;
    endsequence
    sequence ext_read_open;
        slv_on && rd_now;
    endsequence

    chk_latch_follows: assert property (
        ext_write_open |=> s.sc_in == $past(s.sc_s2))
        else $error("input latch did not follow pins during external write");
    chk_ext_read_drive: assert property (
        ext_read_open |=> s.sc_oe == 8'hff && s.sc_out == $past(s.sc_dat))
        else $error("second port not driven during external read");
    chk_sp_out_mux: assert property (
        ##1 1'b1 |-> s.sp_out == (($past(periph_ctl.sel) & $past(periph_ctl.dout))
                     | (~$past(periph_ctl.sel) & $past(s.sp_dat))))
        else $error("shared pin drive value wrong");
    chk_ttl_follows: assert property (
        ##1 1'b1 |-> s.ttl == $past(slv_on))
        else $error("input buffer type does not follow slave mode");
    chk_strobe_dir: assert property (
        ##1 1'b1 |-> s.st_oe == (HAS_SLAVE_PORT ? ~$past(s.st_dir) : 3'h0))
        else $error("strobe pin enable does not follow direction");
    chk_pin_read: assert property (
        take_rd && hi_zero && idx == tpg_pkg::IDX_SP_DAT
        |=> s.hrdata == {24'h00_0000, $past(s.sp_s2)})
        else $error("shared data read does not return pins");
    chk_csr_bit3_zero: assert property (
        take_rd && hi_zero && idx == tpg_pkg::IDX_ST_CSR |=> !s.hrdata[3])
        else $error("unimplemented status bit reads one");
    chk_in_full_clear: assert property (
        take_rd && hi_zero && idx == tpg_pkg::IDX_SC_DAT && slv_on && !wr_done
        |=> !s.in_full)
        else $error("input full not cleared by core read");
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic                 hclk;
    logic                 hresetn;
    logic                 hsel;
    logic                 hwrite;
    logic [31:0]          haddr;
    logic [31:0]          hwdata;
    logic [31:0]          hrdata;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic                 hreadyout;
    logic                 hresp;
    logic                 ttl;
    tpg_pkg::tpg_periph_t periph_ctl;
    logic [7:0]           pp_in;
    logic [7:0]           sp_in;
    logic [7:0]           sp_out;
    logic [7:0]           sp_oe;
    logic [7:0]           sc_in;
    logic [7:0]           sc_out;
    logic [7:0]           sc_oe;
    logic [2:0]           st_in;
    logic [2:0]           st_out;
    logic [2:0]           st_oe;
    logic [31:0]          rd;
    logic [7:0]           xd;
    int                   error_cnt;
    int                   samples_checked;
    int                   cyc;
    tpg_top tpg_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sp_pin_in(sp_in), .sp_pin_out(sp_out), .sp_pin_oe(sp_oe),
        .periph_ctl(periph_ctl), .periph_pin_in(pp_in), .sc_pin_in(sc_in),
        .sc_pin_out(sc_out), .sc_pin_oe(sc_oe), .st_pin_in(st_in),
        .st_pin_out(st_out), .st_pin_oe(st_oe), .input_buffer_ttl(ttl));
    tpg_ext_model tpg_ext_model_i (.hclk(hclk), .sp_pin_out(sp_out), .sp_pin_oe(sp_oe),
        .sc_pin_out(sc_out), .sc_pin_oe(sc_oe), .st_pin_out(st_out),
        .st_pin_oe(st_oe), .sp_pin_in(sp_in), .sc_pin_in(sc_in), .st_pin_in(st_in));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= tpg_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
        xfer(1'b0, idx, 8'h00);
        chk(nm, {24'h0, e}, rd);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("oe", 32'h0, {13'h0, sp_oe, sc_oe, st_oe});
        rdc("csr", tpg_pkg::IDX_ST_CSR, 8'h07);
        rdc("sp_dir", tpg_pkg::IDX_SP_DIR, 8'hff);
        rdc("sc_dir", tpg_pkg::IDX_SC_DIR, 8'hff);
        rdc("analog", tpg_pkg::IDX_ANALOG, 8'h00);
        rdc("st_dat", tpg_pkg::IDX_ST_DAT, 8'h00);
        wr(8'h10, 8'hff);
        rdc("unmapped", 8'h10, 8'h00);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("hready", 32'h1, {31'h0, hreadyout});
    endtask
    task automatic t_shared();
        tpg_ext_model_i.sp_ext <= 8'h5a;
        wr(tpg_pkg::IDX_SP_DAT, 8'ha5);
        wr(tpg_pkg::IDX_SP_DIR, 8'h0f);
        repeat (2) @(posedge hclk);
        chk("sp_oe", 32'hf0, {24'h0, sp_oe});
        chk("sp_out", 32'ha0, {24'h0, sp_out & 8'hf0});
        repeat (3) @(posedge hclk);
        rdc("sp_dat", tpg_pkg::IDX_SP_DAT, 8'haa);
        chk("pp_in", 32'haa, {24'h0, pp_in});
    endtask
    task automatic t_periph();
        periph_ctl <= '{sel: 8'h81, dout: 8'h01, oe: 8'h01};
        repeat (3) @(posedge hclk);
        chk("ovr_oe", 32'h71, {24'h0, sp_oe});
        chk("ovr_out", 32'h1, {31'h0, sp_out[0]});
        periph_ctl <= '{sel: 8'hff, dout: 8'h96, oe: 8'hff};
        repeat (5) @(posedge hclk);
        chk("fn_out", 32'h1ff96, {15'h0, sp_oe, 1'b1, sp_out});
        chk("fn_in", 32'h96, {24'h0, pp_in});
        periph_ctl <= '{sel: 8'h00, dout: 8'hff, oe: 8'hff};
        repeat (3) @(posedge hclk);
        chk("nosel_oe", 32'hf0, {24'h0, sp_oe});
    endtask
    task automatic t_strobe();
        wr(tpg_pkg::IDX_ANALOG, 8'h06);
        wr(tpg_pkg::IDX_ST_DAT, 8'h05);
        wr(tpg_pkg::IDX_ST_CSR, 8'h02);
        repeat (5) @(posedge hclk);
        chk("st_pins", 32'h55, {25'h0, st_oe, 1'b0, st_out & 3'b101});
        rdc("st_dat", tpg_pkg::IDX_ST_DAT, 8'h07);
        wr(tpg_pkg::IDX_ST_CSR, 8'h0f);
        rdc("csr_b3", tpg_pkg::IDX_ST_CSR, 8'h07);
        wr(tpg_pkg::IDX_ANALOG, 8'h00);
        rdc("st_an", tpg_pkg::IDX_ST_DAT, 8'h00);
        wr(tpg_pkg::IDX_ANALOG, 8'h06);
    endtask
    task automatic t_slave();
        wr(tpg_pkg::IDX_SC_DIR, 8'h00);
        wr(tpg_pkg::IDX_SC_DAT, 8'h3c);
        repeat (2) @(posedge hclk);
        chk("sc_io", 32'h0ff3c, {15'h0, ttl, sc_oe, sc_out});
        wr(tpg_pkg::IDX_ST_CSR, 8'h17);
        repeat (2) @(posedge hclk);
        chk("sc_psp", 32'h100, {23'h0, ttl, sc_oe});
        tpg_ext_model_i.bus_write(8'hc3);
        repeat (6) @(posedge hclk);
        rdc("ibf", tpg_pkg::IDX_ST_CSR, 8'h97);
        rdc("sc_in", tpg_pkg::IDX_SC_DAT, 8'hc3);
        rdc("ibf_clr", tpg_pkg::IDX_ST_CSR, 8'h17);
        tpg_ext_model_i.bus_write(8'h11);
        tpg_ext_model_i.bus_write(8'h22);
        repeat (6) @(posedge hclk);
        rdc("ovf", tpg_pkg::IDX_ST_CSR, 8'hb7);
        wr(tpg_pkg::IDX_SC_DAT, 8'h5a);
        rdc("obf", tpg_pkg::IDX_ST_CSR, 8'hf7);
        tpg_ext_model_i.bus_read(xd);
        chk("ext_rd", 32'h5a, {24'h0, xd});
        rdc("obf_clr", tpg_pkg::IDX_ST_CSR, 8'hb7);
        wr(tpg_pkg::IDX_ST_CSR, 8'h27);
        rdc("io_mode", tpg_pkg::IDX_ST_CSR, 8'h27);
        wr(tpg_pkg::IDX_ST_CSR, 8'h07);
        rdc("ovf_clr", tpg_pkg::IDX_ST_CSR, 8'h07);
    endtask
    // ----------------------------------------
    // clock, timeout, main sequence
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        // whole run needs about two hundred cycles
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        periph_ctl = '0;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_shared();
        t_periph();
        t_strobe();
        t_slave();
        give_verdict();
    end
endmodule
`default_nettype wire

// *** sim/tpg_ext_model.sv ***
`default_nettype none
// ----------------------------------------
// pins, peripherals' far side, external bus
// ----------------------------------------
module tpg_ext_model (
    // clock
    input  wire logic       hclk,
    // levels driven by the block
    input  wire logic [7:0] sp_pin_out,
    input  wire logic [7:0] sp_pin_oe,
    input  wire logic [7:0] sc_pin_out,
    input  wire logic [7:0] sc_pin_oe,
    input  wire logic [2:0] st_pin_out,
    input  wire logic [2:0] st_pin_oe,
    // resolved pin levels
    output logic      [7:0] sp_pin_in,
    output logic      [7:0] sc_pin_in,
    output logic      [2:0] st_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sp_ext;
    logic [7:0] sc_ext;
    logic [2:0] st_ext;
    initial begin
        sp_ext = 8'h00;
        sc_ext = 8'h00;
        st_ext = 3'b111;
    end
    // the block wins where it drives, the far side elsewhere
    assign sp_pin_in = (sp_pin_oe & sp_pin_out) | (~sp_pin_oe & sp_ext);
    assign sc_pin_in = (sc_pin_oe & sc_pin_out) | (~sc_pin_oe & sc_ext);
    assign st_pin_in = (st_pin_oe & st_pin_out) | (~st_pin_oe & st_ext);
    // strobes low active: bit0 read, bit1 write, bit2 select
    task automatic bus_write(input logic [7:0] d);
        @(posedge hclk);
        sc_ext <= d;
        st_ext <= 3'b001;
        repeat (6) @(posedge hclk);
        st_ext <= 3'b111;
        repeat (2) @(posedge hclk);
        // released bus must not keep showing the byte
        sc_ext <= ~d;
    endtask
    task automatic bus_read(output logic [7:0] d);
        @(posedge hclk);
        st_ext <= 3'b010;
        repeat (6) @(posedge hclk);
        d = sc_pin_in;
        st_ext <= 3'b111;
    endtask
endmodule
`default_nettype wire
